// >>> bench/tsac_pin_model.sv
`timescale 1ns/1ps
// Stands for the pins outside the block: the interrupt pin and the
// pulled-up shared counter pin, which is pulled low on request.
module tsac_pin_model (
	input  wire logic clock,     // System clock.
	input  wire logic setIrq,    // Wanted interrupt pin level.
	input  wire logic fallReq,   // Request one low pulse.
	output logic      extIrqPin, // Interrupt pin.
	output wire logic cntrPinIn  // Counter pin, pulled up.
);
	logic [2:0] lowCnt = 3'h0; // No pulse pending at start.

	// Follows the wanted level and times each low pulse.
	always @(posedge clock) begin
		extIrqPin <= setIrq;
		if (fallReq)
			lowCnt <= 3'h4;
		else if (lowCnt != 3'h0)
			lowCnt <= lowCnt - 3'h1;
	end

	// The pull-up returns the pin high between pulses.
	assign cntrPinIn = (lowCnt == 3'h0);
endmodule : tsac_pin_model

// >>> bench/tsac_top_tb_top.sv
`timescale 1ns/1ps
module tsac_top_tb_top
	import tsac_pkg::*;
;
	logic              clock, nrst, read, write, intAckA, intAckB;
	logic              setIrq, fallReq, waitrequest, irqReqA, irqReqB;
	logic              extIrqPin, cntrPinIn, cntrPinOut, cntrPinOe, o;
	logic [ADDR_W-1:0] address;
	logic [31:0]       writedata, readdata, q;
	int                fails, totalChecks, cyc;

	tsac_top u_tsac_top (.clock(clock), .nrst(nrst), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest),
		.intAckA(intAckA), .intAckB(intAckB), .irqReqA(irqReqA),
		.irqReqB(irqReqB), .extIrqPin(extIrqPin), .cntrPinIn(cntrPinIn),
		.cntrPinOut(cntrPinOut), .cntrPinOe(cntrPinOe));

	tsac_pin_model u_tsac_pin_model (.clock(clock), .setIrq(setIrq),
		.fallReq(fallReq), .extIrqPin(extIrqPin), .cntrPinIn(cntrPinIn));

	// Free-running 10 MHz clock.
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task automatic chk(input string s, input logic [31:0] e,
		input logic [31:0] g);
		totalChecks++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s exp %h got %h", s, e, g);
		end
	endtask : chk

	task automatic chkBit(input string s, input logic e, input logic g);
		chk(s, {31'h0000_0000, e}, {31'h0000_0000, g});
	endtask : chkBit

	// One bus cycle, raised after an edge and held until the rising
	// edge at which waitrequest is sampled low; data is taken there.
	task automatic acc(input logic w, input logic [ADDR_W-1:0] a,
		input logic [7:0] d);
		@(posedge clock);
		address <= a;
		writedata <= {24'h00_0000, d};
		write <= w;
		read <= ~w;
		do @(posedge clock); while (waitrequest !== 1'b0);
		q = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask : acc

	// Reads up to t times until the masked word matches, then compares.
	task automatic poll(input logic [ADDR_W-1:0] a, input logic [7:0] m,
		input logic [7:0] e, input int t);
		int n;
		n = 0;
		do begin
			acc(1'b0, a, 8'h00);
			n++;
		end while ((q & {24'hFF_FFFF, m}) !== {24'h00_0000, e} && n < t);
		chk($sformatf("reg %h", a), {24'h00_0000, e},
			q & {24'hFF_FFFF, m});
	endtask : poll

	task automatic fall();
		@(posedge clock);
		fallReq <= 1'b1;
		@(posedge clock);
		fallReq <= 1'b0;
		repeat (10) @(posedge clock);
	endtask : fall

	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", totalChecks, fails);
		if (fails == 0 && totalChecks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : giveVerdict

	// Cuts a hang short well past the expected run length.
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			giveVerdict();
		end
	end

	// Main sequence: reset, then one test after another.
	initial begin
		{nrst, read, write, intAckA, intAckB, setIrq, fallReq} = 7'h00;
		address = 6'h00;
		writedata = 32'h0000_0000;
		repeat (10) @(posedge clock);
		nrst <= 1'b1;
		repeat (3) @(posedge clock);
		poll(OFF_CTRL_FIRST, 8'hFF, 8'h00, 1);
		poll(OFF_STATUS, 8'hFF, 8'h00, 1);
		poll(6'h3C, 8'hFF, 8'h00, 1);
		$display("test reset done");
		acc(1'b1, OFF_IRQ_CTRL, 8'h01);
		acc(1'b1, OFF_TMR_A, 8'h02);
		acc(1'b1, OFF_CTRL_FIRST, 8'h0A);
		poll(OFF_STATUS, 8'h01, 8'h01, 300);
		repeat (2) @(negedge clock);
		chkBit("irqReqA", 1'b1, irqReqA);
		acc(1'b1, OFF_CTRL_FIRST, 8'h00);
		poll(OFF_SKIP_A, 8'h01, 8'h01, 1);
		poll(OFF_SKIP_A, 8'h01, 8'h00, 1);
		$display("test timer A done");
		acc(1'b1, OFF_TMR_A, 8'h05);
		acc(1'b1, OFF_PIN_CTRL, 8'h01);
		acc(1'b1, OFF_CTRL_FIRST, 8'h0B);
		setIrq <= 1'b1;
		repeat (10) @(posedge clock);
		poll(OFF_STATUS, 8'hFF, 8'h00, 1);
		poll(OFF_TMR_A, 8'hFF, 8'h05, 1);
		setIrq <= 1'b0;
		poll(OFF_STATUS, 8'h04, 8'h04, 20);
		poll(OFF_STATUS, 8'h01, 8'h01, 300);
		acc(1'b1, OFF_PIN_CTRL, 8'h00);
		poll(OFF_STATUS, 8'h04, 8'h00, 1);
		acc(1'b0, OFF_SKIP_A, 8'h00);
		$display("test start sync done");
		acc(1'b1, OFF_TMR_A, 8'h20);
		acc(1'b1, OFF_CTRL_SECOND, 8'h04);
		acc(1'b1, OFF_PIN_CTRL, 8'h03);
		setIrq <= 1'b1;
		poll(OFF_STATUS, 8'h04, 8'h04, 20);
		poll(OFF_STATUS, 8'h05, 8'h01, 300);
		acc(1'b1, OFF_CTRL_FIRST, 8'h00);
		acc(1'b1, OFF_CTRL_SECOND, 8'h00);
		$display("test auto stop done");
		acc(1'b1, OFF_CTRL_PIN, 8'h03);
		acc(1'b1, OFF_TMR_B, 8'h01);
		acc(1'b1, OFF_CTRL_SECOND, 8'h0A);
		@(negedge clock);
		o = cntrPinOut;
		chkBit("cntrPinOe", 1'b1, cntrPinOe);
		fall();
		poll(OFF_STATUS, 8'h02, 8'h00, 1);
		fall();
		poll(OFF_STATUS, 8'h02, 8'h02, 5);
		@(negedge clock);
		chkBit("irqReqB", 1'b0, irqReqB);
		chkBit("cntrPinOut", ~o, cntrPinOut);
		acc(1'b1, OFF_IRQ_CTRL, 8'h02);
		repeat (2) @(negedge clock);
		chkBit("irqReqB", 1'b1, irqReqB);
		@(posedge clock);
		intAckB <= 1'b1;
		@(posedge clock);
		intAckB <= 1'b0;
		poll(OFF_STATUS, 8'h02, 8'h00, 1);
		acc(1'b1, OFF_CTRL_PIN, 8'h00);
		repeat (2) @(negedge clock);
		chkBit("cntrPinOe", 1'b0, cntrPinOe);
		$display("test counter pin done");
		acc(1'b1, OFF_PORT, 8'h03);
		repeat (2) @(negedge clock);
		chkBit("cntrPinOut", 1'b1, cntrPinOut);
		chkBit("cntrPinOe", 1'b1, cntrPinOe);
		poll(OFF_PORT, 8'hFF, 8'h07, 1);
		$display("test port bit done");
		poll(OFF_SKIP_A, 8'h01, 8'h01, 1);
		acc(1'b1, OFF_TMR_A, 8'h00);
		acc(1'b1, OFF_RELOAD_A, 8'h07);
		poll(OFF_RELOAD_A, 8'hFF, 8'h07, 1);
		poll(OFF_TMR_A, 8'hFF, 8'h00, 1);
		acc(1'b1, OFF_CTRL_FIRST, 8'h0E);
		poll(OFF_STATUS, 8'h01, 8'h01, 100);
		acc(1'b1, OFF_CTRL_FIRST, 8'h00);
		poll(OFF_TMR_A, 8'hFF, 8'h07, 1);
		$display("test reload done");
		giveVerdict();
	end
endmodule : tsac_top_tb_top

// >>> inc/tsac_pkg.sv
// Contract
// - Each timer underflow sets that timer's request flag to 1.
// - Skip test reads a flag; a taken interrupt or skip clears it.
// - Interrupt control bits pick interrupt or polling per timer flag.
// - Bit 0 of first timer control enables timer A start sync.
// - Pin may drive sync only when pin control bit 0 is 1.
// - Pin level change sets sync; edge mode 1 takes both edges.
// - Single-edge polarity bit 2: 0 falling, 1 rising.
// - Once sync is set, count source reaches the timers.
// - Sync stays set until pin enable is cleared, auto-stop clears it, or reset.
// - Auto-stop bit clears sync at timer A underflow.
// - Auto-stop acts only while start sync is selected.
// - Counter pin control bit 0 picks port bit or counter output role.
// - Counter pin output is timer A or B underflow halved.
// - Counter pin source decrements timer B per falling edge.
// - Underflow reloads the counter; value n divides by n plus 1.
// - Timer A counts after loading and run bit 1 set; the code also needs prescaler run bit 3 set.
package tsac_pkg;
	localparam int ADDR_W = 6;
	localparam logic [5:0] OFF_CTRL_FIRST = 6'h00;
	localparam logic [5:0] OFF_CTRL_SECOND = 6'h04;
	localparam logic [5:0] OFF_CTRL_PIN = 6'h08;
	localparam logic [5:0] OFF_PIN_CTRL = 6'h0C;
	localparam logic [5:0] OFF_IRQ_CTRL = 6'h10;
	localparam logic [5:0] OFF_TMR_A = 6'h14;
	localparam logic [5:0] OFF_RELOAD_A = 6'h18;
	localparam logic [5:0] OFF_TMR_B = 6'h1C;
	localparam logic [5:0] OFF_SKIP_A = 6'h20;
	localparam logic [5:0] OFF_SKIP_B = 6'h24;
	localparam logic [5:0] OFF_PORT = 6'h28;
	localparam logic [5:0] OFF_STATUS = 6'h2C;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [7:0] CNT_RESET = 8'h00;
	localparam int PRE_DIV_LO = 4;
	localparam int PRE_DIV_HI = 16;
	localparam logic [1:0] SRC_TMR_A = 2'b00;
	localparam logic [1:0] SRC_PRESCALE = 2'b01;
	localparam logic [1:0] SRC_PIN = 2'b10;
	localparam logic [1:0] SRC_SYSCLK = 2'b11;
endpackage : tsac_pkg

// >>> logic/tsac_top.sv
`timescale 1ns/1ps
module tsac_top
	import tsac_pkg::*;
(
	input  wire logic              clock,       // System clock.
	input  wire logic              nrst,        // Async reset, low.
	input  wire logic [ADDR_W-1:0] address,     // Byte address.
	input  wire logic              read,        // Read request.
	input  wire logic              write,       // Write request.
	input  wire logic [31:0]       writedata,   // Write data.
	output logic      [31:0]       readdata,    // Read data.
	output logic                   waitrequest, // Stall, high.
	input  wire logic              intAckA,     // Timer A irq taken.
	input  wire logic              intAckB,     // Timer B irq taken.
	output logic                   irqReqA,     // Timer A irq request.
	output logic                   irqReqB,     // Timer B irq request.
	input  wire logic              extIrqPin,   // External irq pin.
	input  wire logic              cntrPinIn,   // Shared pin input.
	output logic                   cntrPinOut,  // Shared pin output.
	output logic                   cntrPinOe    // Shared pin enable.
);
	logic [1:0]  rstSyncQ;
	logic        rstN;
	logic [1:0]  intSyncQ, cntSyncQ;
	logic        intPrevQ, cntPrevQ;
	logic [3:0]  ctrlFirstQ, ctrlFirstD, ctrlSecondQ, ctrlSecondD;
	logic [3:0]  ctrlPinQ, ctrlPinD, pinCtrlQ, pinCtrlD;
	logic [3:0]  irqCtrlQ, irqCtrlD;
	logic [7:0]  cntAQ, cntAD, relAQ, relAD, cntBQ, cntBD, relBQ, relBD;
	logic [7:0]  preQ, preD;
	logic        syncQ, syncD, flagAQ, flagAD, flagBQ, flagBD;
	logic        halfQ, halfD, portDataQ, portDataD, portDirQ, portDirD;
	logic        waitQ, waitD;
	logic [31:0] rdataQ, rdataD;
	logic        irqAQ, irqAD, irqBQ, irqBD, outQ, outD, oeQ, oeD;
	logic        rise, fall, edgeOk, cntFall, preTick, gateOk;
	logic        tickA, tickB, srcB, ufA, ufB, wrAcc, rdAcc;
	logic [7:0]  preTop;

	// Decodes one register offset against the bus address.
	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [5:0] off);
		hit = (a == off);
	endfunction : hit

	// Releases the reset through two flip-flops.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rstSyncQ <= 2'b00;
		end else begin
			rstSyncQ <= {rstSyncQ[0], 1'b1};
		end
	end
	assign rstN = rstSyncQ[1];

	// Synchronises both pins before any edge logic looks at them.
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			intSyncQ <= 2'b00;
			cntSyncQ <= 2'b00;
			intPrevQ <= 1'b0;
			cntPrevQ <= 1'b0;
		end else begin
			intSyncQ <= {intSyncQ[0], extIrqPin};
			cntSyncQ <= {cntSyncQ[0], cntrPinIn};
			intPrevQ <= intSyncQ[1];
			cntPrevQ <= cntSyncQ[1];
		end
	end

	// Edge selection, prescaler tick, gating and underflow terms.
	always_comb begin
		rise = intSyncQ[1] & ~intPrevQ;
		fall = ~intSyncQ[1] & intPrevQ;
		if (pinCtrlQ[1]) begin
			edgeOk = rise | fall;
		end else begin
			edgeOk = pinCtrlQ[2] ? rise : fall;
		end
		cntFall = ~cntSyncQ[1] & cntPrevQ;
		preTop = ctrlFirstQ[2] ? 8'(PRE_DIV_HI - 1) : 8'(PRE_DIV_LO - 1);
		preTick = ctrlFirstQ[3] && (preQ == preTop);
		gateOk = ~ctrlFirstQ[0] | syncQ;
		tickA = ctrlFirstQ[1] & preTick & gateOk;
		ufA = tickA && (cntAQ == 8'h00);
		unique case (ctrlSecondQ[1:0])
			SRC_TMR_A: srcB = ufA;
			SRC_PRESCALE: srcB = preTick;
			SRC_PIN: srcB = cntFall;
			SRC_SYSCLK: srcB = 1'b1;
		endcase
		tickB = ctrlSecondQ[3] & srcB & gateOk;
		ufB = tickB && (cntBQ == 8'h00);
		wrAcc = write & ~waitQ;
		rdAcc = read & ~waitQ;
	end

	// Next values of the register file, counters, flags and outputs.
	always_comb begin
		ctrlFirstD = ctrlFirstQ;
		ctrlSecondD = ctrlSecondQ;
		ctrlPinD = ctrlPinQ;
		pinCtrlD = pinCtrlQ;
		irqCtrlD = irqCtrlQ;
		relAD = relAQ;
		relBD = relBQ;
		portDataD = portDataQ;
		portDirD = portDirQ;
		waitD = ~((read | write) & waitQ);
		rdataD = rdataQ;
		if (wrAcc) begin
			if (hit(address, OFF_CTRL_FIRST)) ctrlFirstD = writedata[3:0];
			if (hit(address, OFF_CTRL_SECOND)) ctrlSecondD = writedata[3:0];
			if (hit(address, OFF_CTRL_PIN)) ctrlPinD = writedata[3:0];
			if (hit(address, OFF_PIN_CTRL)) pinCtrlD = writedata[3:0];
			if (hit(address, OFF_IRQ_CTRL)) irqCtrlD = writedata[3:0];
			if (hit(address, OFF_TMR_A) || hit(address, OFF_RELOAD_A)) begin
				relAD = writedata[7:0];
			end
			if (hit(address, OFF_TMR_B)) relBD = writedata[7:0];
			if (hit(address, OFF_PORT)) begin
				portDataD = writedata[0];
				portDirD = writedata[1];
			end
		end
		// Read data is captured in the first cycle of a read.
		if (read & waitQ) begin
			rdataD = 32'h0000_0000;
			unique case (1'b1)
				hit(address, OFF_CTRL_FIRST): rdataD[3:0] = ctrlFirstQ;
				hit(address, OFF_CTRL_SECOND): rdataD[3:0] = ctrlSecondQ;
				hit(address, OFF_CTRL_PIN): rdataD[3:0] = ctrlPinQ;
				hit(address, OFF_PIN_CTRL): rdataD[3:0] = pinCtrlQ;
				hit(address, OFF_IRQ_CTRL): rdataD[3:0] = irqCtrlQ;
				hit(address, OFF_TMR_A): rdataD[7:0] = cntAQ;
				hit(address, OFF_RELOAD_A): rdataD[7:0] = relAQ;
				hit(address, OFF_TMR_B): rdataD[7:0] = cntBQ;
				hit(address, OFF_SKIP_A): rdataD[0] = flagAQ;
				hit(address, OFF_SKIP_B): rdataD[0] = flagBQ;
				hit(address, OFF_PORT): rdataD[2:0] =
					{cntSyncQ[1], portDirQ, portDataQ};
				hit(address, OFF_STATUS): rdataD[2:0] =
					{syncQ, flagBQ, flagAQ};
				default: rdataD = 32'h0000_0000;
			endcase
		end
		// Prescaler clears whenever its run bit is low.
		if (!ctrlFirstQ[3] || preTick) begin
			preD = 8'h00;
		end else begin
			preD = preQ + 8'h01;
		end
		// Counters reload at underflow and load together with reload.
		cntAD = cntAQ;
		if (wrAcc && hit(address, OFF_TMR_A)) begin
			cntAD = writedata[7:0];
		end else if (ufA) begin
			cntAD = relAQ;
		end else if (tickA) begin
			cntAD = cntAQ - 8'h01;
		end
		cntBD = cntBQ;
		if (wrAcc && hit(address, OFF_TMR_B)) begin
			cntBD = writedata[7:0];
		end else if (ufB) begin
			cntBD = relBQ;
		end else if (tickB) begin
			cntBD = cntBQ - 8'h01;
		end
		// Sync sets on a valid edge; a new edge beats the auto-stop clear, not the pin-enable clear.
		syncD = syncQ;
		if (!pinCtrlQ[0]) begin
			syncD = 1'b0;
		end else if (ctrlFirstQ[0] && edgeOk) begin
			syncD = 1'b1;
		end else if (ufA && ctrlSecondQ[2] && ctrlFirstQ[0]) begin
			syncD = 1'b0;
		end
		// Flags: an underflow in the clearing cycle keeps the flag set.
		flagAD = ufA | (flagAQ & ~(intAckA |
			(rdAcc & hit(address, OFF_SKIP_A) & rdataQ[0])));
		flagBD = ufB | (flagBQ & ~(intAckB |
			(rdAcc & hit(address, OFF_SKIP_B) & rdataQ[0])));
		irqAD = flagAQ & irqCtrlQ[0];
		irqBD = flagBQ & irqCtrlQ[1];
		halfD = halfQ ^ (ctrlPinQ[1] ? ufB : ufA);
		outD = ctrlPinQ[0] ? halfQ : portDataQ;
		oeD = ctrlPinQ[0] | portDirQ;
	end

	// Registers all state apart from the reset and pin synchronisers.
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			ctrlFirstQ <= CTRL_RESET;
			ctrlSecondQ <= CTRL_RESET;
			ctrlPinQ <= CTRL_RESET;
			pinCtrlQ <= CTRL_RESET;
			irqCtrlQ <= CTRL_RESET;
			cntAQ <= CNT_RESET;
			relAQ <= CNT_RESET;
			cntBQ <= CNT_RESET;
			relBQ <= CNT_RESET;
			preQ <= CNT_RESET;
			syncQ <= 1'b0;
			flagAQ <= 1'b0;
			flagBQ <= 1'b0;
			halfQ <= 1'b0;
			portDataQ <= 1'b0;
			portDirQ <= 1'b0;
			waitQ <= 1'b1;
			rdataQ <= 32'h0000_0000;
			irqAQ <= 1'b0;
			irqBQ <= 1'b0;
			outQ <= 1'b0;
			oeQ <= 1'b0;
		end else begin
			ctrlFirstQ <= ctrlFirstD;
			ctrlSecondQ <= ctrlSecondD;
			ctrlPinQ <= ctrlPinD;
			pinCtrlQ <= pinCtrlD;
			irqCtrlQ <= irqCtrlD;
			cntAQ <= cntAD;
			relAQ <= relAD;
			cntBQ <= cntBD;
			relBQ <= relBD;
			preQ <= preD;
			syncQ <= syncD;
			flagAQ <= flagAD;
			flagBQ <= flagBD;
			halfQ <= halfD;
			portDataQ <= portDataD;
			portDirQ <= portDirD;
			waitQ <= waitD;
			rdataQ <= rdataD;
			irqAQ <= irqAD;
			irqBQ <= irqBD;
			outQ <= outD;
			oeQ <= oeD;
		end
	end

	assign readdata = rdataQ;
	assign waitrequest = waitQ;
	assign irqReqA = irqAQ;
	assign irqReqB = irqBQ;
	assign cntrPinOut = outQ;
	assign cntrPinOe = oeQ;

	// Checks on flags, sync circuit, reload and pin output.
	sequence s_autoStop;
		ufA && ctrlSecondQ[2] && ctrlFirstQ[0] && pinCtrlQ[0] && !edgeOk;
	endsequence
	property p_flagSetA;
		@(posedge clock) disable iff (!rstN) ufA |=> flagAQ ##1 irqReqA
			== irqCtrlQ[0] || !flagAQ;
	endproperty
	a_flagSetA: assert property (p_flagSetA) else $error("flag A");
	property p_skipClr;
		@(posedge clock) disable iff (!rstN)
		rdAcc && hit(address, OFF_SKIP_A) && rdataQ[0] && !ufA |=> !flagAQ;
	endproperty
	a_skipClr: assert property (p_skipClr) else $error("skip");
	property p_irqGate;
		@(posedge clock) disable iff (!rstN)
		##1 irqReqB == $past(flagBQ & irqCtrlQ[1]);
	endproperty
	a_irqGate: assert property (p_irqGate) else $error("irq");
	property p_syncSet;
		@(posedge clock) disable iff (!rstN)
		$rose(syncQ) |-> $past(ctrlFirstQ[0] && pinCtrlQ[0] && edgeOk);
	endproperty
	a_syncSet: assert property (p_syncSet) else $error("sync set");
	property p_gate;
		@(posedge clock) disable iff (!rstN)
		tickA && ctrlFirstQ[0] |-> syncQ;
	endproperty
	a_gate: assert property (p_gate) else $error("gate");
	property p_syncHold;
		@(posedge clock) disable iff (!rstN)
		syncQ && pinCtrlQ[0] && !(ufA && ctrlSecondQ[2]) |=> syncQ;
	endproperty
	a_syncHold: assert property (p_syncHold) else $error("hold");
	property p_autoStop;
		@(posedge clock) disable iff (!rstN) s_autoStop |=> !syncQ ##1 !tickA;
	endproperty
	a_autoStop: assert property (p_autoStop) else $error("stop");
	property p_reload;
		@(posedge clock) disable iff (!rstN)
		ufA && !(wrAcc && hit(address, OFF_TMR_A)) |=> cntAQ == $past(relAQ);
	endproperty
	a_reload: assert property (p_reload) else $error("reload");
	property p_pinFall;
		@(posedge clock) disable iff (!rstN)
		ctrlSecondQ == {1'b1, 1'b0, SRC_PIN} && cntFall && !ctrlFirstQ[0]
		|-> tickB;
	endproperty
	a_pinFall: assert property (p_pinFall) else $error("pin fall");
	property p_halve;
		@(posedge clock) disable iff (!rstN)
		ctrlPinQ[1] && ufB |=> halfQ != $past(halfQ);
	endproperty
	a_halve: assert property (p_halve) else $error("halve");
endmodule : tsac_top
